// File: rtl/ecbc_top.sv
// management-bus register file with nonvolatile commit, lock and block read length
`default_nettype none
//Contract
// - once lock is set, every later commit is refused, even if lock is cleared.
// - while locked, register writes still apply live but never reach the store.
// - bits [6:0] of byte 26 give block read length; default 27, zero illegal (zero is kept as written; a block read then sends only the count byte).
// - a write cycle starts only on a zero-to-one change of commit bit.
// - commit bit staying high never starts another write cycle.
// - commit bit stays high after programming; only a host write clears it.
// - byte and block reads keep working while programming runs.
// - bits [7:6] of byte 11 choose crystal, two single inputs, or differential.
// - reference input defaults to crystal mode.
// - busy flag high during programming, low after; writes to it ignored.
// - lock is bit 7 of byte 25; one requests permanent lock.
module ecbc_top #(
    parameter logic [6:0] DEV_ADDR = 7'h5A // arbitrary bus address
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // management bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // live configuration and programming busy flag
    output logic [1:0]       ref_input_mode,
    output logic [6:0]       block_read_length,
    output logic [26:0][7:0] config_live,
    output logic             nvm_busy_flag
);
    typedef struct packed {
        logic                  scl_s1;
        logic                  scl_s2;
        logic                  scl_d;
        logic                  sda_s1;
        logic                  sda_s2;
        logic                  sda_d;
        ecbc_pkg::ecbc_state_t st;
        logic [3:0]            bitcnt;
        logic [7:0]            shreg;
        logic                  rw;
        logic                  blk;
        logic                  nack;
        logic [7:0]            ptr;
        logic [6:0]            bcnt;
        logic                  oe;
        logic                  lock;
        logic                  start;
        logic [26:0][7:0]      regs;
    } ecbc_st_t;

    ecbc_st_t s_r;
    ecbc_st_t s_nxt;
    logic     busy;
    logic     scl_rise;
    logic     scl_fall;
    logic     bus_start;
    logic     bus_stop;

    // readback with the busy flag merged into its status bit
    function automatic logic [7:0] read_byte(input logic [26:0][7:0] regs,
                                             input logic [7:0] ptr,
                                             input logic bsy);
        logic [7:0] v;
        v = 8'h00;
        if (ptr < ecbc_pkg::NUM_REGS) begin
            v = regs[ptr[4:0]];
            if (ptr[4:0] == ecbc_pkg::REG_NVM_STATUS) begin
                v[ecbc_pkg::BIT_NVM_BUSY_FLAG] = bsy;
            end
        end
        return v;
    endfunction

    // bus events from the synchronised pins, never from the first stage
    assign scl_rise  = s_r.scl_s2 & ~s_r.scl_d;
    assign scl_fall  = ~s_r.scl_s2 & s_r.scl_d;
    assign bus_start = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;
    assign bus_stop  = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;

    // slave state machine and register file
    always_comb begin
        s_nxt        = s_r;
        s_nxt.scl_s1 = scl_in;
        s_nxt.scl_s2 = s_r.scl_s1;
        s_nxt.scl_d  = s_r.scl_s2;
        s_nxt.sda_s1 = sda_in;
        s_nxt.sda_s2 = s_r.sda_s1;
        s_nxt.sda_d  = s_r.sda_s2;
        s_nxt.start  = 1'b0;
        if (bus_start) begin
            s_nxt.st     = ecbc_pkg::ECBC_ADDR;
            s_nxt.bitcnt = 4'h0;
            s_nxt.oe     = 1'b0;
        end else if (bus_stop) begin
            s_nxt.st = ecbc_pkg::ECBC_IDLE;
            s_nxt.oe = 1'b0;
        end else begin
            unique case (s_r.st)
                ecbc_pkg::ECBC_IDLE: begin
                    s_nxt.oe = 1'b0;
                end
                ecbc_pkg::ECBC_ADDR, ecbc_pkg::ECBC_CMD, ecbc_pkg::ECBC_WDATA: begin
                    if (scl_rise) begin
                        s_nxt.shreg  = {s_r.shreg[6:0], s_r.sda_s2};
                        s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                    end else if (scl_fall && s_r.bitcnt == 4'h8) begin
                        s_nxt.oe = 1'b1;
                        if (s_r.st == ecbc_pkg::ECBC_ADDR) begin
                            s_nxt.rw = s_r.shreg[0];
                            s_nxt.st = ecbc_pkg::ECBC_ADDR_ACK;
                            if (s_r.shreg[7:1] != DEV_ADDR) begin
                                s_nxt.oe = 1'b0;
                                s_nxt.st = ecbc_pkg::ECBC_IDLE;
                            end
                        end else if (s_r.st == ecbc_pkg::ECBC_CMD) begin
                            s_nxt.blk = ~s_r.shreg[ecbc_pkg::BIT_CMD_BYTE_ACCESS];
                            s_nxt.ptr = s_r.shreg[ecbc_pkg::BIT_CMD_BYTE_ACCESS] ?
                                        {1'b0, s_r.shreg[6:0]} : 8'h00;
                            s_nxt.st  = ecbc_pkg::ECBC_CMD_ACK;
                        end else begin
                            // writes always land live, locked or not
                            if (s_r.ptr < ecbc_pkg::NUM_REGS) begin
                                s_nxt.regs[s_r.ptr[4:0]] = s_r.shreg;
                                unique case (s_r.ptr[4:0])
                                    ecbc_pkg::REG_NVM_STATUS: begin
                                        s_nxt.regs[s_r.ptr[4:0]][7] = 1'b0;
                                    end
                                    ecbc_pkg::REG_NVM_LOCK: begin
                                        if (s_r.shreg[ecbc_pkg::BIT_NVM_PERMANENT_LOCK]) begin
                                            s_nxt.lock = 1'b1;
                                        end
                                    end
                                    ecbc_pkg::REG_BLOCK_LENGTH_AND_COMMIT: begin
                                        // only a fresh edge, never a held level
                                        s_nxt.start = s_r.shreg[ecbc_pkg::BIT_NVM_COMMIT_REQUEST]
                                            & ~s_r.regs[ecbc_pkg::REG_BLOCK_LENGTH_AND_COMMIT]
                                                       [ecbc_pkg::BIT_NVM_COMMIT_REQUEST]
                                            & ~s_r.lock & ~busy;
                                    end
                                    default: begin
                                    end
                                endcase
                            end
                            s_nxt.ptr = s_r.ptr + 8'h01;
                            s_nxt.st  = ecbc_pkg::ECBC_WDATA_ACK;
                        end
                    end
                end
                ecbc_pkg::ECBC_ADDR_ACK, ecbc_pkg::ECBC_CMD_ACK, ecbc_pkg::ECBC_WDATA_ACK: begin
                    if (scl_fall) begin
                        s_nxt.oe     = 1'b0;
                        s_nxt.bitcnt = 4'h0;
                        if (s_r.st == ecbc_pkg::ECBC_CMD_ACK ||
                            s_r.st == ecbc_pkg::ECBC_WDATA_ACK) begin
                            s_nxt.st = ecbc_pkg::ECBC_WDATA;
                        end else if (!s_r.rw) begin
                            s_nxt.st = ecbc_pkg::ECBC_CMD;
                        end else begin
                            // reads are served even while programming
                            if (s_r.blk) begin
                                s_nxt.shreg = {1'b0, s_r.regs[ecbc_pkg::REG_BLOCK_LENGTH_AND_COMMIT]
                                                     [ecbc_pkg::BIT_BLOCK_LENGTH_MSB:0]};
                                s_nxt.bcnt  = s_r.regs[ecbc_pkg::REG_BLOCK_LENGTH_AND_COMMIT]
                                                     [ecbc_pkg::BIT_BLOCK_LENGTH_MSB:0];
                            end else begin
                                s_nxt.shreg = read_byte(s_r.regs, s_r.ptr, busy);
                                s_nxt.ptr   = s_r.ptr + 8'h01;
                            end
                            s_nxt.oe = ~s_nxt.shreg[7];
                            s_nxt.st = ecbc_pkg::ECBC_RDATA;
                        end
                    end
                end
                ecbc_pkg::ECBC_RDATA: begin
                    if (scl_rise) begin
                        s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s_r.bitcnt == 4'h8) begin
                            s_nxt.oe = 1'b0;
                            s_nxt.st = ecbc_pkg::ECBC_RDATA_ACK;
                        end else begin
                            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                            s_nxt.oe    = ~s_r.shreg[6];
                        end
                    end
                end
                ecbc_pkg::ECBC_RDATA_ACK: begin
                    if (scl_rise) begin
                        s_nxt.nack = s_r.sda_s2;
                    end else if (scl_fall) begin
                        s_nxt.bitcnt = 4'h0;
                        if (s_r.nack || (s_r.blk && s_r.bcnt == 7'h00)) begin
                            s_nxt.st = ecbc_pkg::ECBC_IDLE;
                        end else begin
                            s_nxt.shreg = read_byte(s_r.regs, s_r.ptr, busy);
                            s_nxt.ptr   = s_r.ptr + 8'h01;
                            s_nxt.bcnt  = s_r.blk ? s_r.bcnt - 7'h01 : s_r.bcnt;
                            s_nxt.oe    = ~s_nxt.shreg[7];
                            s_nxt.st    = ecbc_pkg::ECBC_RDATA;
                        end
                    end
                end
                default: begin
                    s_nxt.st = ecbc_pkg::ECBC_IDLE;
                    s_nxt.oe = 1'b0;
                end
            endcase
        end
    end

    // register stage; lock only clears with a full reset of the model
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r        <= '0;
            s_r.scl_s1 <= 1'b1;
            s_r.scl_s2 <= 1'b1;
            s_r.scl_d  <= 1'b1;
            s_r.sda_s1 <= 1'b1;
            s_r.sda_s2 <= 1'b1;
            s_r.sda_d  <= 1'b1;
            s_r.regs   <= {27{ecbc_pkg::REG_DEFAULT_RST}}; // crystal mode
            s_r.regs[ecbc_pkg::REG_BLOCK_LENGTH_AND_COMMIT] <=
                ecbc_pkg::BLOCK_LENGTH_AND_COMMIT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ecbc_nvm u_nvm (
        .clk        (clk),
        .rst        (rst),
        .start      (s_r.start),
        .live_image (s_r.regs),
        .busy       (busy)
    );

    // outputs straight from flip-flops
    assign sda_out           = 1'b0; // open drain: only ever pulls low
    assign sda_oe            = s_r.oe;
    assign ref_input_mode    = s_r.regs[ecbc_pkg::REG_REF_SELECT]
                                       [ecbc_pkg::BIT_REF_SELECT_LSB +: 2];
    assign block_read_length = s_r.regs[ecbc_pkg::REG_BLOCK_LENGTH_AND_COMMIT]
                                       [ecbc_pkg::BIT_BLOCK_LENGTH_MSB:0];
    assign config_live       = s_r.regs;
    assign nvm_busy_flag     = busy;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic commit_bit;
    assign commit_bit = s_r.regs[ecbc_pkg::REG_BLOCK_LENGTH_AND_COMMIT]
                                [ecbc_pkg::BIT_NVM_COMMIT_REQUEST];

    // status byte as stored and as a read would present it
    logic [7:0] status_kept;
    logic [7:0] status_view;
    assign status_kept = s_r.regs[ecbc_pkg::REG_NVM_STATUS];
    assign status_view = read_byte(s_r.regs, {3'b000, ecbc_pkg::REG_NVM_STATUS}, busy);

    sequence seq_commit_accept;
        s_r.start;
    endsequence
    sequence seq_busy_runs;
        busy [*3];
    endsequence
    sequence seq_locked_ref_write;
        s_r.lock && s_r.st == ecbc_pkg::ECBC_WDATA && scl_fall && s_r.bitcnt == 4'h8 &&
        s_r.ptr == {3'b000, ecbc_pkg::REG_REF_SELECT} && !bus_start && !bus_stop;
    endsequence

    a_commit_on_edge: assert property (s_r.start |-> $rose(commit_bit))
        else $error("commit started without rising request bit");
    a_no_retrigger: assert property ((commit_bit && $past(commit_bit)) |-> !s_r.start)
        else $error("held request bit retriggered programming");
    a_lock_refuses: assert property ($past(s_r.lock) |-> !s_r.start)
        else $error("commit accepted after permanent lock");
    a_lock_sticky: assert property (s_r.lock |=> s_r.lock)
        else $error("permanent lock cleared");
    a_commit_holds: assert property ($fell(commit_bit) |-> $past(s_r.st) == ecbc_pkg::ECBC_WDATA)
        else $error("request bit cleared without host write");
    a_busy_follows: assert property (seq_commit_accept |=> seq_busy_runs)
        else $error("busy flag did not follow commit");
    a_status_ro: assert property (!status_kept[7] && status_view[7] == busy)
        else $error("status bit stored or misreported");
    a_count_byte: assert property ((s_r.st == ecbc_pkg::ECBC_ADDR_ACK && scl_fall && s_r.rw &&
                                    s_r.blk && !bus_start && !bus_stop) |=>
                                   s_r.shreg == {1'b0, block_read_length})
        else $error("block read count byte wrong");
    a_locked_live: assert property (seq_locked_ref_write |=>
                                    ref_input_mode == $past(s_r.shreg[7:6]))
        else $error("locked write did not apply live");
endmodule
`default_nettype wire

// File: rtl/ecbc_pkg.sv
// constants and types shared by the configuration-store controller
`default_nettype none
package ecbc_pkg;
    // clock and timing
    localparam int CLK_FREQ_MHZ          = 20;
    localparam int NVM_BYTE_WRITE_US     = 100;
    localparam int NVM_BYTE_WRITE_CYCLES = NVM_BYTE_WRITE_US * CLK_FREQ_MHZ;

    // register map, byte offsets on the management bus
    localparam logic [7:0] NUM_REGS          = 8'h1B;
    localparam logic [4:0] REG_REF_SELECT    = 5'h0B;
    localparam logic [4:0] REG_NVM_STATUS    = 5'h18;
    localparam logic [4:0] REG_NVM_LOCK      = 5'h19;
    localparam logic [4:0] REG_BLOCK_LENGTH_AND_COMMIT = 5'h1A;

    // field positions
    localparam int BIT_NVM_BUSY_FLAG       = 7;
    localparam int BIT_NVM_PERMANENT_LOCK  = 7;
    localparam int BIT_NVM_COMMIT_REQUEST  = 7;
    localparam int BIT_REF_SELECT_LSB      = 6;
    localparam int BIT_BLOCK_LENGTH_MSB    = 6;

    // values after reset
    localparam logic [7:0] BLOCK_LENGTH_AND_COMMIT_RST = 8'h1B;
    localparam logic [7:0] REG_DEFAULT_RST             = 8'h00;

    // command byte: top bit set selects a single-byte access
    localparam int BIT_CMD_BYTE_ACCESS = 7;

    // reference input source
    typedef enum logic [1:0] {
        ECBC_REF_CRYSTAL      = 2'b00,
        ECBC_REF_SINGLE_A     = 2'b01,
        ECBC_REF_SINGLE_B     = 2'b10,
        ECBC_REF_DIFFERENTIAL = 2'b11
    } ecbc_ref_t;

    // serial slave states
    typedef enum logic [3:0] {
        ECBC_IDLE      = 4'h0,
        ECBC_ADDR      = 4'h1,
        ECBC_ADDR_ACK  = 4'h2,
        ECBC_CMD       = 4'h3,
        ECBC_CMD_ACK   = 4'h4,
        ECBC_WDATA     = 4'h5,
        ECBC_WDATA_ACK = 4'h6,
        ECBC_RDATA     = 4'h7,
        ECBC_RDATA_ACK = 4'h8
    } ecbc_state_t;
endpackage
`default_nettype wire

// File: rtl/ecbc_nvm.sv
// nonvolatile store model: copies the working registers one byte at a time
`default_nettype none
module ecbc_nvm (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // commit request and live image
    input  wire logic              start,
    input  wire logic [26:0][7:0]  live_image,
    // progress
    output logic                   busy
);
    typedef struct packed {
        logic [26:0][7:0] mem;
        logic             busy;
        logic [4:0]       idx;
        logic [15:0]      cnt;
    } ecbc_nvm_st_t;

    ecbc_nvm_st_t s_r;
    ecbc_nvm_st_t s_nxt;

    // one byte per write period; host keeps the image still meanwhile
    always_comb begin
        s_nxt = s_r;
        if (!s_r.busy) begin
            if (start) begin
                s_nxt.busy = 1'b1;
                s_nxt.idx  = 5'h00;
                s_nxt.cnt  = 16'(ecbc_pkg::NVM_BYTE_WRITE_CYCLES - 1);
            end
        end else if (s_r.cnt != 16'h0000) begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
        end else begin
            s_nxt.mem[s_r.idx] = live_image[s_r.idx];
            s_nxt.cnt          = 16'(ecbc_pkg::NVM_BYTE_WRITE_CYCLES - 1);
            if (s_r.idx == 5'(ecbc_pkg::NUM_REGS - 8'h01)) begin
                s_nxt.busy = 1'b0;
            end else begin
                s_nxt.idx = s_r.idx + 5'h01;
            end
        end
    end

    // stored bytes survive reset, control does not
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r.busy <= 1'b0;
            s_r.idx  <= 5'h00;
            s_r.cnt  <= 16'h0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
endmodule
`default_nettype wire

// File: test/ecbc_host.sv
// management-bus host model that drives the clock pin directly and the data pin as an open-drain master
`default_nettype none
module ecbc_host #(
    parameter logic [6:0] DEV_ADDR = 7'h5A
) (
    // clock
    input  wire logic clk,
    // bus pins, data is open drain
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int QTR = 6; // quarter bit; keeps each clock phase well above 4 cycles
    int         nacks;
    logic [7:0] rx[$];

    // idle bus: clock driven high, data line released high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        nacks = 0;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // data changes only while the clock is low, so it never fakes a start or stop
    task automatic xfer_bit(input logic b, output logic r);
        sda_low = ~b;
        idle(QTR);
        scl = 1'b1;
        idle(QTR);
        r = sda;
        idle(QTR);
        scl = 1'b0;
        idle(QTR);
    endtask

    // also serves as repeated start when entered with the clock low
    task automatic start_cond();
        sda_low = 1'b0;
        idle(QTR);
        scl = 1'b1;
        idle(QTR);
        sda_low = 1'b1;
        idle(QTR);
        scl = 1'b0;
        idle(QTR);
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        idle(QTR);
        scl = 1'b1;
        idle(QTR);
        sda_low = 1'b0;
        idle(2 * QTR);
    endtask

    // msb first, then the device acknowledge bit
    task automatic send_byte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        if (r) begin
            nacks++;
        end
    endtask

    // last byte gets a nack so the device lets go of the line
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, d[i]);
        end
        xfer_bit(last, r);
    endtask

    task automatic write_reg(input logic [6:0] ptr, input logic [7:0] d);
        start_cond();
        send_byte({DEV_ADDR, 1'b0});
        send_byte({1'b1, ptr});
        send_byte(d);
        stop_cond();
    endtask

    // byte read when cmd top bit is set, block read when clear; bytes land in rx
    task automatic read_regs(input logic [7:0] cmd, input int n);
        logic [7:0] d;
        rx.delete();
        start_cond();
        send_byte({DEV_ADDR, 1'b0});
        send_byte(cmd);
        start_cond();
        send_byte({DEV_ADDR, 1'b1});
        for (int i = 0; i < n; i++) begin
            recv_byte(i == n - 1, d);
            rx.push_back(d);
        end
        stop_cond();
    endtask
endmodule
`default_nettype wire

// File: test/eeprom_commit_and_block_count_bench.sv
// self-checking bench for the configuration-store controller
`default_nettype none
module eeprom_commit_and_block_count_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [6:0] ptr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } ecbc_row_t;
    // ordinary writes with the value each should read back
    localparam ecbc_row_t ROWS [9] = '{
        '{7'h0B, 8'h00, 8'h00}, '{7'h0B, 8'h40, 8'h40}, '{7'h0B, 8'h80, 8'h80},
        '{7'h0B, 8'hC0, 8'hC0}, '{7'h1A, 8'h01, 8'h01}, '{7'h1A, 8'h7F, 8'h7F},
        '{7'h02, 8'hA5, 8'hA5}, '{7'h18, 8'h80, 8'h00}, '{7'h1E, 8'h77, 8'h00}
    };
    logic             clk;
    logic             rst;
    logic             scl;
    logic             host_low;
    logic             sda_wire;
    logic             sda_out;
    logic             sda_oe;
    logic [1:0]       ref_input_mode;
    logic [6:0]       block_read_length;
    logic [26:0][7:0] config_live;
    logic             nvm_busy_flag;
    int               n_errors;
    int               checked;
    int               polls;

    // open-drain wire with pull-up: low when either party pulls
    assign sda_wire = ~host_low & (sda_oe ? sda_out : 1'b1);

    ecbc_top u_dut (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .ref_input_mode(ref_input_mode),
        .block_read_length(block_read_length), .config_live(config_live),
        .nvm_busy_flag(nvm_busy_flag)
    );
    ecbc_host u_host (.clk(clk), .sda(sda_wire), .scl(scl), .sda_low(host_low));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        n_errors = 0;
        checked = 0;
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        // values straight out of reset
        check("length default", {1'b0, block_read_length}, 8'h1B);
        check("ref default", {6'h00, ref_input_mode}, 8'h00);
        check("busy default", {7'h00, nvm_busy_flag}, 8'h00);
        u_host.read_regs({1'b1, 7'h1A}, 1);
        check("byte26 reset", u_host.rx[0], 8'h1B);
        // table rows: write, read back, and look at the live outputs
        foreach (ROWS[i]) begin
            u_host.write_reg(ROWS[i].ptr, ROWS[i].wdata);
            u_host.read_regs({1'b1, ROWS[i].ptr}, 1);
            check("row readback", u_host.rx[0], ROWS[i].exp);
            if (ROWS[i].ptr < 7'h1B) begin
                check("row live", config_live[ROWS[i].ptr], ROWS[i].exp);
            end
            if (ROWS[i].ptr == 7'h0B) begin
                check("ref mode", {6'h00, ref_input_mode}, {6'h00, ROWS[i].exp[7:6]});
            end
            if (ROWS[i].ptr == 7'h1A) begin
                check("length", {1'b0, block_read_length}, ROWS[i].exp);
            end
        end
        // zero then one gives a fresh edge; also sets a length of three
        u_host.write_reg(7'h1A, 8'h03);
        u_host.write_reg(7'h1A, 8'h83);
        check("busy after edge", {7'h00, nvm_busy_flag}, 8'h01);
        u_host.read_regs(8'h00, 4);
        check("block count", u_host.rx[0], 8'h03);
        check("block byte2", u_host.rx[3], 8'hA5);
        // poll status by reads only; no writes go out while programming runs
        polls = 0;
        do begin
            u_host.read_regs({1'b1, 7'h18}, 1);
            polls++;
            if (polls == 1) begin
                check("busy readback", u_host.rx[0], 8'h80);
            end
        end while (u_host.rx[0][7] === 1'b1 && polls < 75);
        // a poll limit that runs out counts as a mismatch; the rest stays bounded
        if (polls >= 75) begin
            n_errors++;
        end
        check("busy cleared", {7'h00, nvm_busy_flag}, 8'h00);
        u_host.read_regs({1'b1, 7'h1A}, 1);
        check("commit bit held", u_host.rx[0], 8'h83);
        // a level that stays high must not start programming again
        u_host.write_reg(7'h1A, 8'h83);
        check("no retrigger", {7'h00, nvm_busy_flag}, 8'h00);
        // lock, then clear the lock bit: commits stay refused, live writes still land
        u_host.write_reg(7'h19, 8'h80);
        u_host.write_reg(7'h19, 8'h00);
        u_host.write_reg(7'h1A, 8'h05);
        u_host.write_reg(7'h1A, 8'h85);
        check("locked commit", {7'h00, nvm_busy_flag}, 8'h00);
        check("locked length", {1'b0, block_read_length}, 8'h05);
        check("locked byte26", config_live[26], 8'h85);
        // a locked device still changes its live input selection
        u_host.write_reg(7'h0B, 8'h40);
        check("locked ref", {6'h00, ref_input_mode}, 8'h01);
        check("locked no store", {7'h00, nvm_busy_flag}, 8'h00);
        check("host nacks", 8'(u_host.nacks), 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
